/* per_pkg.sv */
// constants shared by the peripheral event router and its prescaler
// assumes a 32-bit apb master and a single peripheral clock
package per_pkg;
	localparam int unsigned NUM_CH      = 4;
	localparam int unsigned SRC_W       = 8;
	localparam int unsigned EXP_W       = 4;
	localparam int unsigned CNT_W       = 15;
	localparam int unsigned ADDR_W      = 8;

	// register byte offsets
	localparam logic [7:0] OFS_SRC0     = 8'h00;
	localparam logic [7:0] OFS_PRESC0   = 8'h10;
	localparam logic [7:0] OFS_DATA     = 8'h20;
	localparam logic [7:0] OFS_STROBE   = 8'h24;
	localparam logic [7:0] OFS_STATUS   = 8'h28;
	localparam logic [7:0] OFS_MODE     = 8'h2c;
	localparam logic [7:0] OFS_STRIDE   = 8'h04;

	// source select codes
	localparam logic [7:0] SRC_NONE     = 8'h00;
	localparam logic [7:0] SRC_GEN_BASE = 8'h01;
	localparam logic [7:0] SRC_PRESC    = 8'h80;

	// field positions in the status word
	localparam int unsigned STAT_SIG_LSB  = 0;
	localparam int unsigned STAT_DATA_LSB = 4;

	// reset values
	localparam logic [7:0] RST_SRC      = 8'h00;
	localparam logic [3:0] RST_EXP      = 4'h0;
	localparam logic [3:0] RST_BITS     = 4'h0;

	// prescaler ratio limits, as exponents of two: 1 .. 32768
	localparam logic [3:0] EXP_MAX      = 4'hf;
endpackage

/* per_presc_if.sv */
// carrier between the router core and one channel prescaler
// assumes both ends share the router clock
`timescale 1ns/1ps
`default_nettype none
interface per_presc_if;
	import per_pkg::*;
	logic [EXP_W-1:0] ratio_exp;
	logic             tick;
	modport core (output ratio_exp, input tick);
	modport div  (input ratio_exp, output tick);
endinterface
`default_nettype wire

/* per_presc.sv */
// one channel's divider of the peripheral clock
// assumes ratio_exp is a four-bit exponent, so it never exceeds 15
`timescale 1ns/1ps
`default_nettype none
module per_presc
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	per_presc_if.div  pif
);
	import per_pkg::*;

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             tick_ff;
	logic             nxt_tick;
	logic [CNT_W-1:0] last;

	always_comb
	begin
		// terminal count is ratio minus one
		last = CNT_W'({CNT_W{1'b1}} >> (EXP_MAX - pif.ratio_exp)); // [RULE4]
		if (pif.ratio_exp == RST_EXP)
		begin
			last = '0;
		end
		// >= so a smaller ratio written mid-count does not wrap the counter
		nxt_tick = (cnt_ff >= last); // [RULE5]
		nxt_cnt  = nxt_tick ? '0 : CNT_W'(cnt_ff + 1'b1);
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end
		else if (ce_in)
		begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign pif.tick = tick_ff;
endmodule
`default_nettype wire

/* per_router.sv */
// peripheral event router: four channels, apb registers, prescalers
// assumes generator inputs are synchronous one-cycle pulses or levels
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] four channels, each a software-set mux forwarding one source
// [RULE2] generator event reaches channel output within two clock cycles
// [RULE3] routing runs in active and idle sleep alike, no sleep gating
// [RULE4] each channel has its own divider, ratio 1 up to 32768
// [RULE5] each channel can emit periodic events from its own divider
// [RULE6] strobe register write injects software event using held data bits
// [RULE7] software writes data register before strobe register
// [RULE8] data and strobe hold one bit per channel; many bits fire together
// [RULE9] software event lasts one cycle and overrides generator event
// [RULE10] strobe/data pairs encode no event, 01, 02, 03; strobe gives signaling
// [RULE11] signaling output carries only occurrence; data bits carry extra information
// [RULE12] any source reaches any user; plain users see only signaling pulse
// [RULE13] per-channel mode bit tells data-capable users which interpretation
// [RULE14] routed events are one-cycle pulses unless the source holds a level
// [RULE15] source select zero routes no generator, software events still pass
// [RULE16] channel signaling and data outputs are registered for all users
module per_router
#(
	parameter int unsigned NUM_SRC = 16
)
(
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	input  wire logic                          ce_in,
	input  wire logic                          psel_in,
	input  wire logic                          penable_in,
	input  wire logic                          pwrite_in,
	input  wire logic [per_pkg::ADDR_W-1:0]    paddr_in,
	input  wire logic [31:0]                   pwdata_in,
	output var  logic [31:0]                   prdata_out,
	output var  logic                          pready_out,
	output var  logic                          pslverr_out,
	input  wire logic [NUM_SRC-1:0]            gen_sig_in,
	input  wire logic [NUM_SRC-1:0]            gen_data_in,
	output var  logic [per_pkg::NUM_CH-1:0]    ch_sig_out,
	output var  logic [2*per_pkg::NUM_CH-1:0]  ch_data_out,
	output var  logic [per_pkg::NUM_CH-1:0]    user_data_mode_out
);
	import per_pkg::*;

	// software-visible state
	logic [SRC_W-1:0]  src_ff     [NUM_CH];
	logic [SRC_W-1:0]  nxt_src    [NUM_CH];
	logic [EXP_W-1:0]  exp_ff     [NUM_CH];
	logic [EXP_W-1:0]  nxt_exp    [NUM_CH];
	logic [NUM_CH-1:0] data_ff;
	logic [NUM_CH-1:0] nxt_data;
	logic [NUM_CH-1:0] mode_ff;
	logic [NUM_CH-1:0] nxt_mode;

	// apb answer
	logic [31:0]       prdata_ff;
	logic [31:0]       nxt_prdata;
	logic              pready_ff;
	logic              nxt_pready;
	logic              pslverr_ff;
	logic              nxt_pslverr;

	// software injection, one cycle wide
	logic              inj_ff;
	logic              nxt_inj;
	logic [NUM_CH-1:0] inj_strb_ff;
	logic [NUM_CH-1:0] nxt_inj_strb;
	logic [NUM_CH-1:0] inj_data_ff;
	logic [NUM_CH-1:0] nxt_inj_data;

	// channel outputs
	logic [NUM_CH-1:0]   sig_ff;
	logic [NUM_CH-1:0]   nxt_sig;
	logic [2*NUM_CH-1:0] dat_ff;
	logic [2*NUM_CH-1:0] nxt_dat;

	// prescaler ticks and bus decode helpers
	logic [NUM_CH-1:0] tick;
	logic              setup;
	logic              access;
	logic              wr;
	logic              mapped;
	logic [31:0]       rd_word;
	logic [EXP_W-1:0]  wexp;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_div
			per_presc_if pif ();
			assign pif.ratio_exp = exp_ff[g];
			assign tick[g]       = pif.tick;
			per_presc i_per_presc
			(
				.clk_in (clk_in),
				.rst_in (rst_in),
				.ce_in  (ce_in),
				.pif    (pif)
			);
		end
	endgenerate

	// register decode; read data is prepared in the setup cycle
	always_comb
	begin
		setup   = psel_in & ~penable_in;
		access  = psel_in & penable_in & pready_ff;
		wr      = access & pwrite_in;
		mapped  = 1'b0;
		rd_word = '0;
		// per-channel select and ratio words sit at a fixed stride
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (paddr_in == ADDR_W'(OFS_SRC0 + OFS_STRIDE * i))
			begin
				mapped  = 1'b1;
				rd_word = 32'(src_ff[i]);
			end
			if (paddr_in == ADDR_W'(OFS_PRESC0 + OFS_STRIDE * i))
			begin
				mapped  = 1'b1;
				rd_word = 32'(exp_ff[i]);
			end
		end
		// shared registers; anything else stays unmapped and reads zero
		unique case (paddr_in)
			OFS_DATA:
			begin
				mapped  = 1'b1;
				rd_word = 32'(data_ff);
			end
			OFS_STROBE:
			begin
				// write-only trigger, reads zero
				mapped  = 1'b1;
			end
			OFS_STATUS:
			begin
				mapped  = 1'b1;
				rd_word = 32'(sig_ff) << STAT_SIG_LSB;
				rd_word = rd_word | (32'(dat_ff) << STAT_DATA_LSB);
			end
			OFS_MODE:
			begin
				mapped  = 1'b1;
				rd_word = 32'(mode_ff);
			end
			default:
			begin
			end
		endcase
	end

	// apb answer: ready one cycle after setup, so every access takes one wait-free cycle
	always_comb
	begin
		nxt_pready  = setup;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = pslverr_ff;
		if (setup)
		begin
			nxt_prdata  = pwrite_in ? 32'h0000_0000 : rd_word;
			nxt_pslverr = ~mapped;
		end
		else if (access)
		begin
			// error flag drops once its own access completes
			nxt_pslverr = 1'b0;
		end
	end

	// configuration writes
	always_comb
	begin
		nxt_data = data_ff;
		nxt_mode = mode_ff;
		wexp     = pwdata_in[EXP_W-1:0];
		// writes land at the access edge only, never at setup
		for (int i = 0; i < NUM_CH; i++)
		begin
			nxt_src[i] = src_ff[i];
			nxt_exp[i] = exp_ff[i];
			if (wr && paddr_in == ADDR_W'(OFS_SRC0 + OFS_STRIDE * i))
			begin
				nxt_src[i] = pwdata_in[SRC_W-1:0]; // [RULE1]
			end
			if (wr && paddr_in == ADDR_W'(OFS_PRESC0 + OFS_STRIDE * i))
			begin
				nxt_exp[i] = wexp; // [RULE4]
			end
		end
		if (wr && paddr_in == OFS_DATA)
		begin
			nxt_data = pwdata_in[NUM_CH-1:0]; // [RULE8]
		end
		// mode is a plain copy for the users; routing ignores it
		if (wr && paddr_in == OFS_MODE)
		begin
			nxt_mode = pwdata_in[NUM_CH-1:0]; // [RULE13]
		end
	end

	// strobe write fires; data bits as held now, so data must be written first
	always_comb
	begin
		nxt_inj      = wr && (paddr_in == OFS_STROBE); // [RULE6] [RULE7]
		nxt_inj_strb = pwdata_in[NUM_CH-1:0]; // [RULE8]
		nxt_inj_data = data_ff;
		// stale bits are zeroed so nothing fires again next cycle
		if (!nxt_inj)
		begin
			nxt_inj_strb = '0;
			nxt_inj_data = '0;
		end
	end

	// channel muxes; no sleep input exists, so idle sleep keeps routing
	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			// zero and unknown codes route nothing
			nxt_sig[i]         = 1'b0; // [RULE15] [RULE3]
			nxt_dat[2*i +: 2]  = 2'b00;
			for (int s = 0; s < NUM_SRC; s++)
			begin
				if (src_ff[i] == SRC_W'(SRC_GEN_BASE + s))
				begin
					// pulse or held level passes as the source drives it
					nxt_sig[i]        = gen_sig_in[s]; // [RULE1] [RULE12] [RULE14]
					nxt_dat[2*i +: 2] = {gen_sig_in[s], gen_data_in[s]}; // [RULE11]
				end
			end
			// own tick carries no data bit: a pure signaling event
			if (src_ff[i] == SRC_PRESC)
			begin
				nxt_sig[i]        = tick[i]; // [RULE5]
				nxt_dat[2*i +: 2] = {tick[i], 1'b0};
			end
			// software event wins for its one cycle
			if (inj_ff && (inj_strb_ff[i] || inj_data_ff[i]))
			begin
				nxt_sig[i]        = inj_strb_ff[i]; // [RULE9] [RULE10] [RULE15]
				nxt_dat[2*i +: 2] = {inj_strb_ff[i], inj_data_ff[i]}; // [RULE10]
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				src_ff[i] <= RST_SRC;
				exp_ff[i] <= RST_EXP;
			end
			data_ff     <= RST_BITS;
			mode_ff     <= RST_BITS;

			prdata_ff   <= '0;
			pready_ff   <= 1'b0;
			pslverr_ff  <= 1'b0;

			inj_ff      <= 1'b0;
			inj_strb_ff <= '0;
			inj_data_ff <= '0;

			sig_ff      <= '0;
			dat_ff      <= '0;
		end
		else if (ce_in)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				src_ff[i] <= nxt_src[i];
				exp_ff[i] <= nxt_exp[i];
			end
			data_ff     <= nxt_data;
			mode_ff     <= nxt_mode;

			prdata_ff   <= nxt_prdata;
			pready_ff   <= nxt_pready;
			pslverr_ff  <= nxt_pslverr;

			inj_ff      <= nxt_inj; // [RULE9]
			inj_strb_ff <= nxt_inj_strb;
			inj_data_ff <= nxt_inj_data;

			// one register stage so all users see the event together
			sig_ff      <= nxt_sig; // [RULE16] [RULE2]
			dat_ff      <= nxt_dat; // [RULE16]
		end
	end

	assign prdata_out         = prdata_ff;
	assign pready_out         = pready_ff;
	assign pslverr_out        = pslverr_ff;
	assign ch_sig_out         = sig_ff;
	assign ch_data_out        = dat_ff;
	assign user_data_mode_out = mode_ff; // [RULE13]
endmodule
`default_nettype wire

/* per_checker.sv */
// port assertions for the event router
// assumes ce_in stays high through apb transfers
`timescale 1ns/1ps
`default_nettype none
module per_checker
#(
	parameter int unsigned NUM_SRC = 16
)
(
	input wire logic                         clk_in,
	input wire logic                         rst_in,
	input wire logic                         ce_in,
	input wire logic                         psel_in,
	input wire logic                         penable_in,
	input wire logic                         pwrite_in,
	input wire logic [per_pkg::ADDR_W-1:0]   paddr_in,
	input wire logic [31:0]                  pwdata_in,
	input wire logic [31:0]                  prdata_out,
	input wire logic                         pready_out,
	input wire logic                         pslverr_out,
	input wire logic [NUM_SRC-1:0]           gen_sig_in,
	input wire logic [NUM_SRC-1:0]           gen_data_in,
	input wire logic [per_pkg::NUM_CH-1:0]   ch_sig_out,
	input wire logic [2*per_pkg::NUM_CH-1:0] ch_data_out,
	input wire logic [per_pkg::NUM_CH-1:0]   user_data_mode_out
);
	import per_pkg::*;
	logic [7:0] src0_ff;
	logic [7:0] nxt_src0;
	logic       wr;
	logic       wr_stb;
	assign wr = psel_in && penable_in && pready_out && pwrite_in && ce_in;
	assign wr_stb = wr && paddr_in == OFS_STROBE;
	// shadow of channel 0 select, so routing can be judged
	always_comb
		nxt_src0 = (wr && paddr_in == OFS_SRC0) ? pwdata_in[7:0] : src0_ff;
	always_ff @(posedge clk_in)
		src0_ff <= rst_in ? RST_SRC : nxt_src0;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	a_ready_next: assert property (psel_in && !penable_in && ce_in |=> pready_out)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready_out && ce_in |=> !pready_out)
		else $error("ready too long");
	a_err_map: assert property (psel_in && !penable_in && ce_in && paddr_in > OFS_MODE
		|=> pslverr_out)
		else $error("unmapped not refused");
	a_sig_strobe: assert property (ch_sig_out == {ch_data_out[7], ch_data_out[5],
		ch_data_out[3], ch_data_out[1]})
		else $error("signal and strobe bit differ");
	// an injection landing in the same cycle may legally override
	a_route_gen: assert property (gen_sig_in[0] && ce_in && src0_ff == SRC_GEN_BASE
		&& !$past(wr_stb) |=> ch_data_out[1:0] == {1'b1, $past(gen_data_in[0])})
		else $error("generator event late");
	a_zero_src: assert property (src0_ff == SRC_NONE && !$past(wr_stb)
		|=> !ch_sig_out[0])
		else $error("event on unselected channel");
	a_inj_sig: assert property (wr_stb && pwdata_in[0] ##1 ce_in |=> ch_sig_out[0])
		else $error("strobe not injected");
	a_mode_copy: assert property (wr && paddr_in == OFS_MODE
		|-> ##2 user_data_mode_out == $past(pwdata_in[3:0], 2))
		else $error("mode output wrong");
	cover property (wr_stb);
	cover property (ch_sig_out[0] && src0_ff == SRC_PRESC);
	cover property (pslverr_out);
endmodule
bind per_router per_checker #(.NUM_SRC(NUM_SRC)) i_per_checker (.*);
`default_nettype wire

/* per_gen_model.sv */
// stand-in for the on-chip event generators
// assumes requests change right after clock edges
`timescale 1ns/1ps
`default_nettype none
module per_gen_model
#(
	parameter int unsigned NUM_SRC = 16
)
(
	input  wire logic               clk_in,
	input  wire logic [NUM_SRC-1:0] fire_in,
	input  wire logic [NUM_SRC-1:0] data_in,
	output var  logic [NUM_SRC-1:0] gen_sig_out,
	output var  logic [NUM_SRC-1:0] gen_data_out
);
	// data held low when idle: a lone data bit would read as event 01
	always_ff @(posedge clk_in)
	begin
		gen_sig_out <= fire_in;
		gen_data_out <= fire_in & data_in;
	end
endmodule
`default_nettype wire

/* per_router_bench.sv */
// self-checking bench for the event router
// assumes per_gen_model feeds the generator inputs
`timescale 1ns/1ps
`default_nettype none
module per_router_bench;
	import per_pkg::*;
	logic        clk_in = 0;
	logic        rst_in = 1;
	logic        ce_in = 1;
	logic        psel_in = 0;
	logic        penable_in = 0;
	logic        pwrite_in = 0;
	logic [7:0]  paddr_in = 0;
	logic [31:0] pwdata_in = 0;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic [15:0] gen_sig_in;
	logic [15:0] gen_data_in;
	logic [3:0]  ch_sig_out;
	logic [7:0]  ch_data_out;
	logic [3:0]  user_data_mode_out;
	logic [15:0] fire = 0;
	logic [15:0] gdat = 0;
	logic [31:0] rv;
	logic        er;
	logic [3:0]  ex [4] = '{4'h2, 4'h0, 4'h3, 4'hf};
	int          n_errors = 0;
	int          comparisons = 0;
	int          cnt [4] = '{0, 0, 0, 0};
	int          base [4];
	per_router i_per_router (.*);
	per_gen_model i_per_gen_model (.clk_in(clk_in), .fire_in(fire), .data_in(gdat),
		.gen_sig_out(gen_sig_in), .gen_data_out(gen_data_in));
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in)
		for (int i = 0; i < 4; i++)
			cnt[i] <= cnt[i] + ch_sig_out[i];
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1;
		t = 0;
		do
		begin
			@(posedge clk_in);
			t++;
		end
		while (pready_out !== 1'b1 && t < 20);
		if (t >= 20)
			n_errors++;
		rv = prdata_out;
		er = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic fire_chk(input logic [15:0] f, input logic [15:0] d, input logic [11:0] e);
		@(posedge clk_in);
		fire <= f;
		gdat <= d;
		@(posedge clk_in);
		fire <= 0;
		gdat <= 0;
		@(posedge clk_in);
		#1 chk({ch_sig_out, ch_data_out}, e);
		@(posedge clk_in);
		#1 chk({ch_sig_out, ch_data_out}, 0);
	endtask
	task automatic sw(input logic [3:0] d, input logic [3:0] s, input logic [11:0] e);
		xfer(1, OFS_DATA, 32'(d));
		repeat (2) @(posedge clk_in);
		#1 chk({ch_sig_out, ch_data_out}, 0);
		xfer(1, OFS_STROBE, 32'(s));
		@(posedge clk_in);
		#1 chk({ch_sig_out, ch_data_out}, e);
		@(posedge clk_in);
		#1 chk({ch_sig_out, ch_data_out}, 0);
	endtask
	task automatic results();
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// whole run is about 33k cycles
	initial
	begin
		#4ms;
		n_errors++;
		results();
	end
	initial
	begin
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		for (int i = 0; i < 12; i++)
		begin
			xfer(0, 8'(4 * i), 0);
			chk(rv, 0);
		end
		xfer(0, 8'h30, 0);
		chk({31'h0, er}, 1);
		xfer(1, 8'h30, 32'h1);
		chk({31'h0, er}, 1);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1, OFS_SRC0 + 8'(4 * i), 32'(i + 1));
			xfer(0, OFS_SRC0 + 8'(4 * i), 0);
			chk(rv, 32'(i + 1));
		end
		xfer(1, OFS_MODE, 32'ha);
		xfer(0, OFS_MODE, 0);
		chk({rv[31:4], user_data_mode_out}, 32'ha);
		fire_chk(16'hf, 16'h5, {4'hf, 8'hbb});
		xfer(1, OFS_SRC0, 0);
		xfer(1, OFS_SRC0 + 8'h4, 1);
		fire_chk(16'h1, 16'h1, {4'h2, 8'h0c});
		// clock enable low: the router must miss this event entirely
		@(posedge clk_in);
		ce_in <= 0;
		fire_chk(16'h1, 16'h1, 0);
		@(posedge clk_in);
		ce_in <= 1;
		sw(4'ha, 4'hc, {4'hc, 8'he4});
		sw(4'h0, 4'h1, {4'h1, 8'h02});
		for (int i = 0; i < 4; i++)
		begin
			xfer(1, OFS_SRC0 + 8'(4 * i), 32'(SRC_PRESC));
			xfer(1, OFS_PRESC0 + 8'(4 * i), 32'(ex[i]));
		end
		repeat (32) @(posedge clk_in);
		#1 base = cnt;
		repeat (64) @(posedge clk_in);
		for (int i = 0; i < 3; i++)
			#1 chk(cnt[i] - base[i], 64 >> ex[i]);
		repeat (32704) @(posedge clk_in);
		#1 chk(cnt[3] - base[3], 1);
		// channel 1 at ratio 1 shows a steady signaling event in status
		xfer(0, OFS_STATUS, 0);
		chk(rv & 32'h0000_00c2, 32'h0000_0082);
		results();
	end
endmodule
`default_nettype wire
